// >>> common/tsr_cfg.svh
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
// Register indices (pointer values)
`define TSR_A_RESULT   8'h00
`define TSR_A_CONFIG   8'h01
`define TSR_A_UPPER    8'h02
`define TSR_A_LOWER    8'h03
`define TSR_A_UNLOCK   8'h04
`define TSR_A_USER1    8'h05
`define TSR_A_USER2    8'h06
`define TSR_A_CORR     8'h07
`define TSR_A_USER3    8'h08
`define TSR_A_PARTID   8'h0F
// Reset values
`define TSR_RST_RESULT 16'h8000
`define TSR_RST_CONFIG 16'h0220
`define TSR_RST_UPPER  16'h6000
`define TSR_RST_LOWER  16'h8000
`define TSR_RST_ZERO   16'h0000
// Arbitrary neutral identifier value
`define TSR_PART_ID    16'h5A01
// Configuration and unlock field positions
`define TSR_B_HIGH     15
`define TSR_B_LOW      14
`define TSR_B_DRDY     13
`define TSR_B_BUSY     12
`define TSR_B_MODE_HI  11
`define TSR_B_MODE_LO  10
`define TSR_B_CYC_HI   9
`define TSR_B_CYC_LO   7
`define TSR_B_AVG_HI   6
`define TSR_B_AVG_LO   5
`define TSR_B_THERM    4
`define TSR_B_POL      3
`define TSR_B_SRC      2
`define TSR_B_SRST     1
`define TSR_B_UNLOCK   15
// Timing
`define TSR_CLK_HZ     20000000
`define TSR_SRST_US    2000
`define TSR_TICK_US    500
`define TSR_NVLOAD_CYC 16
`endif

// >>> common/tsr_pkg.sv
package tsr_pkg;
  typedef enum logic [1:0] {
    TSR_CONT,
    TSR_SHUT,
    TSR_CONT2,
    TSR_SHOT
  } tsr_mode_t;
  typedef enum logic [1:0] {
    TSR_LOAD,
    TSR_IDLE,
    TSR_CONV,
    TSR_WAIT
  } tsr_state_t;
endpackage : tsr_pkg

// >>> rtl/tsr_avg.sv
`timescale 1ns/1ps
module tsr_avg
  import tsr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Samples
  input  wire logic        i_restart,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_sample,
  input  wire logic [1:0]  i_avg,
  // Block mean
  output logic             o_valid,
  output logic [15:0]      o_mean
);
  logic [22:0] acc_q;
  logic [6:0]  num_q;
  logic [6:0]  need;
  logic [22:0] sum;

  always_comb begin
    case (i_avg)
      2'h0: need = 7'h01;
      2'h1: need = 7'h08;
      2'h2: need = 7'h20;
      default: need = 7'h40;
    endcase
    sum = acc_q + {{7{i_sample[15]}}, i_sample};
  end

  // Fresh block each time, not a running mean
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_restart) begin
      acc_q   <= '0;
      num_q   <= '0;
      o_valid <= 1'b0;
      o_mean  <= '0;
    end else begin
      o_valid <= 1'b0;
      if (i_valid) begin
        // Also closes a block cut short by a smaller averaging setting
        if (num_q + 7'h01 >= need) begin
          acc_q   <= '0;
          num_q   <= '0;
          o_valid <= 1'b1;
          case (i_avg)
            2'h0: o_mean <= sum[15:0];
            2'h1: o_mean <= sum[18:3];
            2'h2: o_mean <= sum[20:5];
            default: o_mean <= sum[21:6];
          endcase
        end else begin
          acc_q <= sum;
          num_q <= num_q + 7'h01;
        end
      end
    end
  end
endmodule : tsr_avg

// >>> rtl/tsr_regbank.sv
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_regbank
  import tsr_pkg::*;
#(
  parameter int SRST_CYC = (`TSR_SRST_US * (`TSR_CLK_HZ / 1000000)),
  parameter int TICK_CYC = (`TSR_TICK_US * (`TSR_CLK_HZ / 1000000))
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Register access by pointer
  input  wire logic [7:0]  i_ptr,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Nonvolatile copy of reset values
  input  wire logic [15:0] i_nv_config,
  input  wire logic [15:0] i_nv_upper,
  input  wire logic [15:0] i_nv_lower,
  input  wire logic [15:0] i_nv_corr,
  input  wire logic [15:0] i_nv_user1,
  input  wire logic [15:0] i_nv_user2,
  input  wire logic [15:0] i_nv_user3,
  input  wire logic        i_nv_prog_busy,
  // Conversion engine
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_data,
  output logic             o_conv_start,
  // Alert pin
  output logic             o_alert
);
  localparam int BUSY_W = $clog2(SRST_CYC + 1);

  tsr_state_t  st_q;
  logic [15:0] result_q, upper_q, lower_q, corr_q, user1_q, user2_q, user3_q;
  logic        unlock_q, high_q, low_q, drdy_q, therm_q, pol_q, src_q;
  logic [1:0]  mode_q, avg_q;
  logic [2:0]  cyc_q;
  logic [BUSY_W-1:0] hold_q;
  logic [5:0]  wait_q;
  logic [5:0]  cyc_ticks;
  logic        tick, pub_v, nv_load, srst, ld_busy, pend_q;
  logic [15:0] pub_d, cfg_rd, corr_s;
  logic        wr_cfg;

  // ---------------------------------------------------------------
  // Cycle timing and averaging
  // ---------------------------------------------------------------
  tsr_tick #(.DIV(TICK_CYC)) u_tick (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .o_tick (tick)
  );

  assign corr_s = i_conv_data + corr_q;

  tsr_avg u_avg (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_restart (nv_load),
    .i_valid   (i_conv_done && st_q == TSR_CONV),
    .i_sample  (corr_s),
    .i_avg     (avg_q),
    .o_valid   (pub_v),
    .o_mean    (pub_d)
  );

  // Standby counted in 0.5 ms ticks; shortest cycles wait a single tick
  always_comb begin
    case (cyc_q)
      3'h4: cyc_ticks = 6'd2;
      3'h5: cyc_ticks = 6'd8;
      3'h6: cyc_ticks = 6'd16;
      3'h7: cyc_ticks = 6'd32;
      default: cyc_ticks = 6'd1;
    endcase
  end

  // ---------------------------------------------------------------
  // Reset load and soft reset
  // ---------------------------------------------------------------
  assign wr_cfg  = i_wr && i_ptr == `TSR_A_CONFIG;
  assign srst    = wr_cfg && i_wdata[`TSR_B_SRST];
  assign nv_load = st_q == TSR_LOAD && hold_q == '0;
  assign ld_busy = st_q == TSR_LOAD;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q   <= TSR_LOAD;
      hold_q <= BUSY_W'(`TSR_NVLOAD_CYC);
      wait_q <= '0;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (srst) begin
        st_q   <= TSR_LOAD;
        hold_q <= BUSY_W'(SRST_CYC);
      end else begin
        case (st_q)
          TSR_LOAD: begin
            if (hold_q != '0) begin
              hold_q <= hold_q - 1'b1;
            end else begin
              st_q <= TSR_IDLE;
            end
          end
          TSR_IDLE: begin
            if (mode_q != 2'(TSR_SHUT)) begin
              st_q <= TSR_CONV;
              o_conv_start <= 1'b1;
            end
          end
          TSR_CONV: begin
            if (pub_v) begin
              st_q   <= TSR_WAIT;
              wait_q <= '0;
            end else if (pend_q) begin
              // One cycle late, so the block's last sample asks for no extra one
              o_conv_start <= 1'b1;
            end
          end
          default: begin
            if (mode_q == 2'(TSR_SHUT) || mode_q == 2'(TSR_SHOT)) begin
              st_q <= TSR_IDLE;
            end else if (wait_q >= cyc_ticks) begin
              st_q <= TSR_CONV;
              o_conv_start <= 1'b1;
            end else if (tick) begin
              wait_q <= wait_q + 6'd1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= i_conv_done && st_q == TSR_CONV;
    end
  end

  // ---------------------------------------------------------------
  // Result and writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst || nv_load) begin
      result_q <= `TSR_RST_RESULT;
    end else if (pub_v) begin
      result_q <= pub_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      upper_q  <= `TSR_RST_UPPER;
      lower_q  <= `TSR_RST_LOWER;
      corr_q   <= `TSR_RST_ZERO;
      user1_q  <= `TSR_RST_ZERO;
      user2_q  <= `TSR_RST_ZERO;
      user3_q  <= `TSR_RST_ZERO;
      unlock_q <= 1'b0;
    end else if (nv_load) begin
      upper_q  <= i_nv_upper;
      lower_q  <= i_nv_lower;
      corr_q   <= i_nv_corr;
      user1_q  <= i_nv_user1;
      user2_q  <= i_nv_user2;
      user3_q  <= i_nv_user3;
      unlock_q <= 1'b0;
    end else if (i_wr && !ld_busy) begin
      if (i_ptr == `TSR_A_UPPER) begin
        upper_q <= i_wdata;
      end else if (i_ptr == `TSR_A_LOWER) begin
        lower_q <= i_wdata;
      end else if (i_ptr == `TSR_A_UNLOCK) begin
        unlock_q <= i_wdata[`TSR_B_UNLOCK];
      end else if (i_ptr == `TSR_A_USER1) begin
        user1_q <= i_wdata;
      end else if (i_ptr == `TSR_A_USER2) begin
        user2_q <= i_wdata;
      end else if (i_ptr == `TSR_A_CORR) begin
        corr_q <= i_wdata;
      end else if (i_ptr == `TSR_A_USER3) begin
        user3_q <= i_wdata;
      end
    end
  end

  // Configuration control fields; flags and busy stay untouched by writes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_q  <= 2'(`TSR_RST_CONFIG >> `TSR_B_MODE_LO);
      cyc_q   <= 3'(`TSR_RST_CONFIG >> `TSR_B_CYC_LO);
      avg_q   <= 2'(`TSR_RST_CONFIG >> `TSR_B_AVG_LO);
      therm_q <= 1'b0;
      pol_q   <= 1'b0;
      src_q   <= 1'b0;
    end else if (nv_load) begin
      mode_q  <= {1'b0, i_nv_config[`TSR_B_MODE_LO]};
      cyc_q   <= i_nv_config[`TSR_B_CYC_HI:`TSR_B_CYC_LO];
      avg_q   <= i_nv_config[`TSR_B_AVG_HI:`TSR_B_AVG_LO];
      therm_q <= i_nv_config[`TSR_B_THERM];
      pol_q   <= i_nv_config[`TSR_B_POL];
      src_q   <= i_nv_config[`TSR_B_SRC];
    end else begin
      if (wr_cfg && !srst && !ld_busy) begin
        mode_q  <= i_wdata[`TSR_B_MODE_HI:`TSR_B_MODE_LO];
        cyc_q   <= i_wdata[`TSR_B_CYC_HI:`TSR_B_CYC_LO];
        avg_q   <= i_wdata[`TSR_B_AVG_HI:`TSR_B_AVG_LO];
        therm_q <= i_wdata[`TSR_B_THERM];
        pol_q   <= i_wdata[`TSR_B_POL];
        src_q   <= i_wdata[`TSR_B_SRC];
      end else if (pub_v && mode_q == 2'(TSR_SHOT)) begin
        mode_q <= 2'(TSR_SHUT);
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags: a new result wins over a clearing read in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst || nv_load) begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
      drdy_q <= 1'b0;
    end else begin
      if (pub_v) begin
        drdy_q <= 1'b1;
      end else if (i_rd && (i_ptr == `TSR_A_RESULT || i_ptr == `TSR_A_CONFIG)) begin
        drdy_q <= 1'b0;
      end
      if (therm_q) begin
        low_q <= 1'b0;
        if (pub_v) begin
          if ($signed(pub_d) > $signed(upper_q)) begin
            high_q <= 1'b1;
          end else if ($signed(pub_d) < $signed(lower_q)) begin
            high_q <= 1'b0;
          end
        end
      end else begin
        if (pub_v && $signed(pub_d) > $signed(upper_q)) begin
          high_q <= 1'b1;
        end else if (i_rd && i_ptr == `TSR_A_CONFIG) begin
          high_q <= 1'b0;
        end
        if (pub_v && $signed(pub_d) < $signed(lower_q)) begin
          low_q <= 1'b1;
        end else if (i_rd && i_ptr == `TSR_A_CONFIG) begin
          low_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux and alert pin
  // ---------------------------------------------------------------
  always_comb begin
    cfg_rd = '0;
    cfg_rd[`TSR_B_HIGH] = high_q;
    cfg_rd[`TSR_B_LOW]  = low_q && !therm_q;
    cfg_rd[`TSR_B_DRDY] = drdy_q;
    cfg_rd[`TSR_B_BUSY] = ld_busy || i_nv_prog_busy;
    cfg_rd[`TSR_B_MODE_HI:`TSR_B_MODE_LO] =
      (mode_q == 2'(TSR_CONT2)) ? 2'(TSR_CONT) : mode_q;
    cfg_rd[`TSR_B_CYC_HI:`TSR_B_CYC_LO] = cyc_q;
    cfg_rd[`TSR_B_AVG_HI:`TSR_B_AVG_LO] = avg_q;
    cfg_rd[`TSR_B_THERM] = therm_q;
    cfg_rd[`TSR_B_POL]   = pol_q;
    cfg_rd[`TSR_B_SRC]   = src_q;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_alert <= 1'b1;
    end else begin
      if (i_ptr == `TSR_A_RESULT) begin
        o_rdata <= result_q;
      end else if (i_ptr == `TSR_A_CONFIG) begin
        o_rdata <= cfg_rd;
      end else if (i_ptr == `TSR_A_UPPER) begin
        o_rdata <= upper_q;
      end else if (i_ptr == `TSR_A_LOWER) begin
        o_rdata <= lower_q;
      end else if (i_ptr == `TSR_A_UNLOCK) begin
        o_rdata <= {unlock_q, cfg_rd[`TSR_B_BUSY], 14'h0000};
      end else if (i_ptr == `TSR_A_USER1) begin
        o_rdata <= user1_q;
      end else if (i_ptr == `TSR_A_USER2) begin
        o_rdata <= user2_q;
      end else if (i_ptr == `TSR_A_CORR) begin
        o_rdata <= corr_q;
      end else if (i_ptr == `TSR_A_USER3) begin
        o_rdata <= user3_q;
      end else if (i_ptr == `TSR_A_PARTID) begin
        o_rdata <= `TSR_PART_ID;
      end else begin
        o_rdata <= '0;
      end
      o_alert <= (src_q ? drdy_q : (high_q | low_q)) ~^ pol_q;
    end
  end
endmodule : tsr_regbank

// >>> rtl/tsr_tick.sv
`timescale 1ns/1ps
module tsr_tick
  import tsr_pkg::*;
#(
  parameter int DIV = 10000
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Tick
  output logic      o_tick
);
  logic [$clog2(DIV)-1:0] cnt_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == $clog2(DIV)'(DIV - 1)) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : tsr_tick

// >>> testbench/tsr_conv_model.sv
`timescale 1ns/1ps
module tsr_conv_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Conversion handshake
  input  wire logic        i_start,
  input  wire logic [15:0] i_temp,
  output logic             o_done,
  output logic [15:0]      o_data
);
  int cnt;
  // Data toggles while not valid so a stale sample is never mistaken
  always_ff @(posedge i_mclk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_rst) begin
      cnt    <= 0;
      o_data <= 16'h0000;
    end else if (cnt == 1) begin
      cnt    <= 0;
      o_done <= 1'b1;
      o_data <= i_temp;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (i_start) begin
      cnt <= LAT;
    end
  end
endmodule : tsr_conv_model

// >>> testbench/tsr_regbank_props.sv
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_regbank_props (
  // Watched ports
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_ptr,
  input wire logic        i_nv_prog_busy,
  input wire logic [15:0] o_rdata,
  input wire logic        o_conv_start,
  input wire logic        o_alert
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  AST_PART_ID: assert property (
    !$past(i_rst) && $past(i_ptr) == 8'h0F |-> o_rdata == `TSR_PART_ID) else $error("bad id");
  AST_SRST_ZERO: assert property (
    $past(i_ptr) == 8'h01 |-> !o_rdata[1]) else $error("soft reset bit read 1");
  AST_MODE_NO10: assert property (
    $past(i_ptr) == 8'h01 |-> o_rdata[11:10] != 2'b10) else $error("mode read 10");
  AST_THERM_LOW: assert property (
    $past(i_ptr) == 8'h01 && o_rdata[4] |-> !o_rdata[14]) else $error("low flag in therm");
  AST_RST_OUT: assert property (
    $fell(i_rst) |-> o_rdata == 16'h0000 && o_alert && !o_conv_start) else $error("reset out");
  AST_LOAD_BUSY: assert property (
    $fell(i_rst) && i_ptr == 8'h01 ##1 i_ptr == 8'h01 |=> o_rdata[12]) else $error("no busy");
  AST_PROG_BUSY: assert property (
    (i_nv_prog_busy && i_ptr == 8'h01)[*3] |=> o_rdata[12]) else $error("prog not busy");
  AST_START_PULSE: assert property (
    o_conv_start |=> !o_conv_start) else $error("start too long");
  cover property ($past(i_ptr) == 8'h01 && o_rdata[15]);
  cover property (o_alert ##1 !o_alert);
  cover property (o_conv_start);
endmodule : tsr_regbank_props

bind tsr_regbank tsr_regbank_props u_tsr_regbank_props (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_ptr(i_ptr), .i_nv_prog_busy(i_nv_prog_busy), .o_rdata(o_rdata),
  .o_conv_start(o_conv_start), .o_alert(o_alert));

// >>> testbench/tsr_regbank_tb.sv
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_regbank_tb;
  import tsr_pkg::*;
  logic        i_mclk, i_rst, i_wr, i_rd, i_nv_prog_busy, i_conv_done, o_conv_start, o_alert;
  logic [7:0]  i_ptr;
  logic [15:0] i_wdata, o_rdata, i_conv_data, temp;
  logic [15:0] nv [7];
  int          n_mismatch, num_checks, n_done;

  tsr_regbank #(.SRST_CYC(20), .TICK_CYC(4)) u_tsr_regbank (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_ptr(i_ptr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_nv_config(nv[0]), .i_nv_upper(nv[1]), .i_nv_lower(nv[2]), .i_nv_corr(nv[3]),
    .i_nv_user1(nv[4]), .i_nv_user2(nv[5]), .i_nv_user3(nv[6]),
    .i_nv_prog_busy(i_nv_prog_busy), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_conv_start(o_conv_start), .o_alert(o_alert));
  tsr_conv_model u_tsr_conv_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(o_conv_start),
    .i_temp(temp), .o_done(i_conv_done), .o_data(i_conv_data));

  always @(posedge i_mclk) if (i_conv_done === 1'b1) n_done++;

  // ----------------------------------------
  // Check and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge i_mclk) begin
      i_ptr   <= p;
      i_wdata <= d;
      i_wr    <= 1'b1;
    end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask : wr
  // Value is captured before the clearing pulse so it shows the flags as they were
  task automatic rd(input logic [7:0] p, input logic clr, output logic [15:0] v);
    @(posedge i_mclk) i_ptr <= p;
    repeat (2) @(posedge i_mclk);
    #1 v = o_rdata;
    if (clr) begin
      @(posedge i_mclk) i_rd <= 1'b1;
      @(posedge i_mclk) i_rd <= 1'b0;
    end
  endtask : rd
  task automatic shot(input logic [15:0] t, input logic [1:0] avg, input logic [2:0] tps,
                      output logic [15:0] v);
    int k;
    @(posedge i_mclk) temp <= t;
    n_done = 0;
    wr(8'h01, {4'h0, 2'b11, 3'b000, avg, tps, 2'b00});
    k = 0;
    do begin
      rd(8'h01, 1'b0, v);
      k++;
    end while (!(v[11:10] === 2'b01 && v[13] === 1'b1) && k < 300);
  endtask : shot

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [15:0] v;
    logic [7:0]  pt [10] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0F, 8'h09};
    logic [15:0] ex [10] = '{16'h8000, 16'h5F00, 16'h8100, 16'h0000, 16'h1357, 16'h2468,
                             16'h0000, 16'hA5C3, `TSR_PART_ID, 16'h0000};
    int          k = 0;
    do begin
      rd(8'h01, 1'b0, v);
      k++;
    end while (v[12] !== 1'b0 && k < 20);
    chk(v, 16'h0220, "cfg");
    for (int i = 0; i < 10; i++) begin
      rd(pt[i], 1'b0, v);
      chk(v, ex[i], "reset value");
    end
    wr(8'h01, 16'h0420);
    repeat (300) @(posedge i_mclk);
    rd(8'h01, 1'b1, v);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ro;
    logic [15:0] v, r0;
    rd(8'h00, 1'b0, r0);
    wr(8'h00, 16'h1234);
    wr(8'h0F, 16'h1234);
    wr(8'h01, 16'hF420);
    rd(8'h00, 1'b0, v);
    chk(v, r0, "result");
    rd(8'h01, 1'b0, v);
    chk(v, 16'h0420, "cfg flags");
    wr(8'h01, 16'h0800);
    rd(8'h01, 1'b0, v);
    chk({14'h0, v[11:10]}, 16'h0000, "mode");
    wr(8'h01, 16'h0420);
    repeat (300) @(posedge i_mclk);
    rd(8'h01, 1'b1, v);
    $display("t_ro done");
  endtask : t_ro
  task automatic t_alert;
    logic [15:0] v;
    int          cnt [4] = '{1, 8, 32, 64};
    wr(8'h02, 16'h0640);
    wr(8'h03, 16'h0000);
    for (int a = 0; a < 4; a++) begin
      shot(16'h0C80 + 16'(a), 2'(a), 3'b010, v);
      chk(16'(n_done), 16'(cnt[a]), "samples");
      rd(8'h00, 1'b0, v);
      chk(v, 16'h0C80 + 16'(a), "mean");
    end
    rd(8'h01, 1'b1, v);
    chk({14'h0, v[15], v[13]}, 16'h0003, "flags");
    #1 chk({15'h0, o_alert}, 16'h0001, "pin");
    rd(8'h01, 1'b0, v);
    chk({14'h0, v[15], v[13]}, 16'h0000, "flags cleared");
    chk({15'h0, o_alert}, 16'h0000, "pin");
    shot(16'hFF00, 2'b00, 3'b000, v);
    chk({15'h0, v[14]}, 16'h0001, "low");
    chk({15'h0, o_alert}, 16'h0000, "pin");
    rd(8'h01, 1'b1, v);
    shot(16'h0100, 2'b00, 3'b011, v);
    chk({15'h0, o_alert}, 16'h0001, "pin");
    rd(8'h00, 1'b1, v);
    chk(v, 16'h0100, "result");
    rd(8'h01, 1'b0, v);
    chk({15'h0, v[13]}, 16'h0000, "ready");
    chk({15'h0, o_alert}, 16'h0000, "pin");
    $display("t_alert done");
  endtask : t_alert
  task automatic t_therm;
    logic [15:0] v;
    shot(16'h0C80, 2'b00, 3'b100, v);
    rd(8'h01, 1'b1, v);
    rd(8'h01, 1'b0, v);
    chk({14'h0, v[15], v[14]}, 16'h0002, "read keeps");
    shot(16'h0100, 2'b00, 3'b100, v);
    chk({15'h0, v[15]}, 16'h0001, "hysteresis");
    shot(16'hFF00, 2'b00, 3'b100, v);
    chk({14'h0, v[15], v[14]}, 16'h0000, "cleared");
    @(posedge i_mclk) i_nv_prog_busy <= 1'b1;
    repeat (4) @(posedge i_mclk);
    #1 chk({15'h0, o_rdata[12]}, 16'h0001, "busy");
    @(posedge i_mclk) i_nv_prog_busy <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 chk({15'h0, o_rdata[12]}, 16'h0000, "busy");
    $display("t_therm done");
  endtask : t_therm
  task automatic t_srst;
    logic [15:0] v;
    int          k = 0;
    wr(8'h01, 16'h0002);
    rd(8'h01, 1'b0, v);
    chk({15'h0, v[12]}, 16'h0001, "srst busy");
    chk({15'h0, v[1]}, 16'h0000, "srst bit");
    do begin
      rd(8'h01, 1'b0, v);
      k++;
    end while (v[12] !== 1'b0 && k < 20);
    chk(v, 16'h0220, "cfg reload");
    rd(8'h02, 1'b0, v);
    chk(v, 16'h5F00, "upper reload");
    rd(8'h00, 1'b0, v);
    chk(v, `TSR_RST_RESULT, "result reload");
    $display("t_srst done");
  endtask : t_srst
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (40000) @(posedge i_mclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_nv_prog_busy} = 4'b1000;
    i_ptr   = 8'h01;
    i_wdata = 16'h0000;
    temp    = 16'h0C80;
    nv      = '{16'h0220, 16'h5F00, 16'h8100, 16'h0000, 16'h1357, 16'h2468, 16'hA5C3};
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_ro();
    t_alert();
    t_therm();
    t_srst();
    tally_and_finish();
  end
endmodule : tsr_regbank_tb
